// [bsctap_pkg.sv]
package bsctap_pkg;

  // register lengths
  localparam int IR_LEN = 10;
  localparam int BSR_LEN = 960;
  localparam int SIG_LEN = 32;
  localparam int USER_BITS = 7;
  localparam int CFG_W = 8;
  localparam int FIFO_DEPTH = 16;

  // instruction opcodes, all distinct, all ones is bypass
  localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_LEN-1:0] OP_CFG_LOAD = 10'h002;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_LEN-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3ff;

  // fixed pattern loaded into the instruction shifter on capture
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;

  // identification fields, values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h5;
  localparam logic [15:0] ID_PART = 16'ha5c3;
  localparam logic [10:0] ID_MAKER = 11'h2b4;
  localparam logic [SIG_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // fixed upper part of the user signature, value arbitrary
  localparam logic [SIG_LEN-USER_BITS-1:0] SIG_FIXED = 25'h1_5543;

  // values after reset
  localparam logic [IR_LEN-1:0] IR_RESET = OP_IDCODE;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bsctap_state_t;

  // status captured by the configuration-load data register
  typedef struct packed {
    logic overflow;
    logic pending;
  } bsctap_cfg_stat_t;

  // one configuration byte on its way to the fifo
  typedef struct packed {
    logic valid;
    logic [CFG_W-1:0] data;
  } bsctap_cfg_word_t;

endpackage

// [bsctap_fifo.sv]
module bsctap_fifo #(
  parameter int W = bsctap_pkg::CFG_W,
  parameter int DEPTH = bsctap_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic vld;
    logic [W-1:0] head;
  } bsctap_fifo_t;

  bsctap_fifo_t r;
  bsctap_fifo_t nxt;
  logic push;
  logic pop;

  assign in_ready = r.cnt != (AW + 1)'(DEPTH);
  assign out_valid = r.vld;
  assign out_data = r.head;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    nxt = r;
    if (push) begin
      nxt.mem[r.wr] = in_data;
      nxt.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
    end
    if (pop) begin
      nxt.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
    end
    // simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      nxt.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt.cnt = r.cnt - 1'b1;
    end
    if (sys_rst) begin
      nxt.wr = '0;
      nxt.rd = '0;
      nxt.cnt = '0;
    end
    // head kept in flops so the outputs need no read mux
    nxt.vld = nxt.cnt != '0;
    nxt.head = nxt.mem[nxt.rd];
  end

  always_ff @(posedge clk) begin
    r <= nxt;
  end

endmodule

// [bsctap_top.sv]
module bsctap_top #(
  parameter int NPIN = bsctap_pkg::BSR_LEN / 3,
  parameter int FIFO_DEPTH = bsctap_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic config_busy,
  input wire logic [bsctap_pkg::USER_BITS-1:0] user_sig,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] core_out,
  input wire logic [NPIN-1:0] core_oe,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic [bsctap_pkg::CFG_W-1:0] cfg_data,
  output logic cfg_valid,
  input wire logic cfg_ready
);

  localparam int BL = 3 * NPIN;
  localparam int IRL = bsctap_pkg::IR_LEN;
  localparam int UB = bsctap_pkg::USER_BITS;
  localparam int CW = bsctap_pkg::CFG_W;
  localparam int SL = bsctap_pkg::SIG_LEN;

  // link side, all on tck
  typedef struct packed {
    bsctap_pkg::bsctap_state_t st;
    logic [IRL-1:0] ir_sh;
    logic [IRL-1:0] ir;
    logic [BL-1:0] dr_sh;
    logic [BL-1:0] bsr_upd;
    logic [BL-1:0] cap1;
    logic [BL-1:0] cap2;
    logic [BL-1:0] cap3;
    logic [BL-1:0] cap_st;
    logic [2:0] busy_s;
    logic busy_st;
    logic [UB-1:0] us1;
    logic [UB-1:0] us2;
    logic [UB-1:0] us3;
    logic [UB-1:0] us_st;
    logic [2:0] rst_s;
    logic [2:0] ack_s;
    logic ack_st;
    logic upd_tgl;
    logic ext_lvl;
    logic [CW-1:0] cfg_byte;
    logic req_tgl;
    logic overflow;
  } bsctap_tck_t;

  // output stage, on falling tck
  typedef struct packed {
    logic tdo;
    logic oe;
  } bsctap_neg_t;

  // system side, all on clk
  typedef struct packed {
    logic [2:0] upd_s;
    logic upd_st;
    logic upd_seen;
    logic [2:0] ext_s;
    logic ext_st;
    logic [2:0] req_s;
    logic req_st;
    logic ack;
    logic [BL-1:0] upd_copy;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe;
  } bsctap_clk_t;

  bsctap_tck_t t_r;
  bsctap_tck_t t_nxt;
  bsctap_neg_t n_r;
  bsctap_neg_t n_nxt;
  bsctap_clk_t c_r;
  bsctap_clk_t c_nxt;

  logic t_rst;
  logic [IRL-1:0] op;
  bsctap_pkg::bsctap_cfg_stat_t stat;
  bsctap_pkg::bsctap_cfg_word_t push_w;
  logic fifo_in_ready;

  // a bit counts once the second and third stages agree
  function automatic logic settle(logic held, logic s2, logic s3);
    settle = (s2 == s3) ? s3 : held;
  endfunction

  function automatic logic [BL-1:0] settle_v(logic [BL-1:0] held, logic [BL-1:0] s2, logic [BL-1:0] s3);
    settle_v = (s2 & s3) | (held & (s2 ^ s3));
  endfunction

  function automatic bsctap_pkg::bsctap_state_t tap_next(bsctap_pkg::bsctap_state_t s, logic m);
    unique case (s)
      bsctap_pkg::TLR: tap_next = m ? bsctap_pkg::TLR : bsctap_pkg::RTI;
      bsctap_pkg::RTI: tap_next = m ? bsctap_pkg::SEL_DR : bsctap_pkg::RTI;
      bsctap_pkg::SEL_DR: tap_next = m ? bsctap_pkg::SEL_IR : bsctap_pkg::CAP_DR;
      bsctap_pkg::CAP_DR: tap_next = m ? bsctap_pkg::EX1_DR : bsctap_pkg::SH_DR;
      bsctap_pkg::SH_DR: tap_next = m ? bsctap_pkg::EX1_DR : bsctap_pkg::SH_DR;
      bsctap_pkg::EX1_DR: tap_next = m ? bsctap_pkg::UPD_DR : bsctap_pkg::PAU_DR;
      bsctap_pkg::PAU_DR: tap_next = m ? bsctap_pkg::EX2_DR : bsctap_pkg::PAU_DR;
      bsctap_pkg::EX2_DR: tap_next = m ? bsctap_pkg::UPD_DR : bsctap_pkg::SH_DR;
      bsctap_pkg::UPD_DR: tap_next = m ? bsctap_pkg::SEL_DR : bsctap_pkg::RTI;
      bsctap_pkg::SEL_IR: tap_next = m ? bsctap_pkg::TLR : bsctap_pkg::CAP_IR;
      bsctap_pkg::CAP_IR: tap_next = m ? bsctap_pkg::EX1_IR : bsctap_pkg::SH_IR;
      bsctap_pkg::SH_IR: tap_next = m ? bsctap_pkg::EX1_IR : bsctap_pkg::SH_IR;
      bsctap_pkg::EX1_IR: tap_next = m ? bsctap_pkg::UPD_IR : bsctap_pkg::PAU_IR;
      bsctap_pkg::PAU_IR: tap_next = m ? bsctap_pkg::EX2_IR : bsctap_pkg::PAU_IR;
      bsctap_pkg::EX2_IR: tap_next = m ? bsctap_pkg::UPD_IR : bsctap_pkg::SH_IR;
      bsctap_pkg::UPD_IR: tap_next = m ? bsctap_pkg::SEL_DR : bsctap_pkg::RTI;
    endcase
  endfunction

  // decode of the held instruction into the one that acts
  function automatic logic [IRL-1:0] eff_op(logic [IRL-1:0] ir, logic busy);
    eff_op = bsctap_pkg::OP_BYPASS;
    if ((ir == bsctap_pkg::OP_SAMPLE || ir == bsctap_pkg::OP_EXTEST) && !busy) begin
      eff_op = ir;
    end
    if (ir == bsctap_pkg::OP_IDCODE || ir == bsctap_pkg::OP_USERCODE || ir == bsctap_pkg::OP_CFG_LOAD) begin
      eff_op = ir;
    end
  endfunction

  // tdi enters at the top of the selected register, tdo leaves bit 0
  function automatic logic [BL-1:0] dr_shift(logic [IRL-1:0] o, logic [BL-1:0] d, logic b);
    logic [BL-1:0] s;
    s = d >> 1;
    if (o == bsctap_pkg::OP_IDCODE || o == bsctap_pkg::OP_USERCODE) begin
      s[SL-1] = b;
    end else if (o == bsctap_pkg::OP_CFG_LOAD) begin
      s[CW-1] = b;
    end else if (o == bsctap_pkg::OP_SAMPLE || o == bsctap_pkg::OP_EXTEST) begin
      s[BL-1] = b;
    end else begin
      s[0] = b;
    end
    dr_shift = s;
  endfunction

  // dedicated logic, independent of the user core
  assign t_rst = t_r.rst_s[1] & t_r.rst_s[2];
  assign op = eff_op(t_r.ir, t_r.busy_st);
  assign stat.pending = t_r.req_tgl ^ t_r.ack_st;
  assign stat.overflow = t_r.overflow;

  always_comb begin
    t_nxt = t_r;
    // boundary cells: inputs nearest tdo, then outputs, then enables
    t_nxt.cap1 = {core_oe, core_out, pin_in};
    t_nxt.cap2 = t_r.cap1;
    t_nxt.cap3 = t_r.cap2;
    t_nxt.cap_st = settle_v(t_r.cap_st, t_r.cap2, t_r.cap3);
    t_nxt.busy_s = {t_r.busy_s[1:0], config_busy};
    t_nxt.busy_st = settle(t_r.busy_st, t_r.busy_s[1], t_r.busy_s[2]);
    t_nxt.us1 = user_sig;
    t_nxt.us2 = t_r.us1;
    t_nxt.us3 = t_r.us2;
    for (int i = 0; i < UB; i++) begin
      t_nxt.us_st[i] = settle(t_r.us_st[i], t_r.us2[i], t_r.us3[i]);
    end
    t_nxt.rst_s = {t_r.rst_s[1:0], sys_rst};
    t_nxt.ack_s = {t_r.ack_s[1:0], c_r.ack};
    t_nxt.ack_st = settle(t_r.ack_st, t_r.ack_s[1], t_r.ack_s[2]);
    t_nxt.st = tap_next(t_r.st, tms);
    if (t_r.st == bsctap_pkg::TLR) begin
      t_nxt.ir = bsctap_pkg::IR_RESET;
    end else if (t_r.st == bsctap_pkg::CAP_IR) begin
      t_nxt.ir_sh = bsctap_pkg::IR_CAPTURE;
    end else if (t_r.st == bsctap_pkg::SH_IR) begin
      t_nxt.ir_sh = {tdi, t_r.ir_sh[IRL-1:1]};
    end else if (t_r.st == bsctap_pkg::UPD_IR) begin
      t_nxt.ir = t_r.ir_sh;
    end else if (t_r.st == bsctap_pkg::CAP_DR) begin
      t_nxt.dr_sh = '0;
      if (op == bsctap_pkg::OP_IDCODE) begin
        t_nxt.dr_sh[SL-1:0] = bsctap_pkg::ID_WORD;
      end else if (op == bsctap_pkg::OP_USERCODE) begin
        t_nxt.dr_sh[SL-1:0] = {bsctap_pkg::SIG_FIXED, t_r.us_st};
      end else if (op == bsctap_pkg::OP_CFG_LOAD) begin
        t_nxt.dr_sh[1:0] = stat;
      end else if (op != bsctap_pkg::OP_BYPASS) begin
        t_nxt.dr_sh = t_r.cap_st;
      end
    end else if (t_r.st == bsctap_pkg::SH_DR) begin
      t_nxt.dr_sh = dr_shift(op, t_r.dr_sh, tdi);
    end else if (t_r.st == bsctap_pkg::UPD_DR) begin
      if (op == bsctap_pkg::OP_SAMPLE || op == bsctap_pkg::OP_EXTEST) begin
        t_nxt.bsr_upd = t_r.dr_sh;
        t_nxt.upd_tgl = ~t_r.upd_tgl;
      end else if (op == bsctap_pkg::OP_CFG_LOAD) begin
        // hand byte over, or flag it lost while one still waits
        if (stat.pending) begin
          t_nxt.overflow = 1'b1;
        end else begin
          t_nxt.cfg_byte = t_r.dr_sh[CW-1:0];
          t_nxt.req_tgl = ~t_r.req_tgl;
        end
      end
    end

    // overflow clears once the status has been captured
    if (t_r.st == bsctap_pkg::CAP_DR && op == bsctap_pkg::OP_CFG_LOAD) begin
      t_nxt.overflow = 1'b0;
    end

    // from the next instruction: tck may stop right after update-ir
    t_nxt.ext_lvl = eff_op(t_nxt.ir, t_nxt.busy_st) == bsctap_pkg::OP_EXTEST;

    if (t_rst) begin
      t_nxt.st = bsctap_pkg::TLR;
      t_nxt.ir = bsctap_pkg::IR_RESET;
      t_nxt.ir_sh = '0;
      t_nxt.dr_sh = '0;
      t_nxt.bsr_upd = '0;
      t_nxt.busy_st = 1'b0;
      t_nxt.us_st = '0;
      t_nxt.cap_st = '0;
      t_nxt.ack_st = 1'b0;
      t_nxt.upd_tgl = 1'b0;
      t_nxt.req_tgl = 1'b0;
      t_nxt.ext_lvl = 1'b0;
      t_nxt.cfg_byte = '0;
      t_nxt.overflow = 1'b0;
    end
  end

  always_ff @(posedge tck) begin
    t_r <= t_nxt;
  end

  // tdo launched on falling tck, floating outside shift states
  always_comb begin
    n_nxt.oe = t_r.st == bsctap_pkg::SH_DR || t_r.st == bsctap_pkg::SH_IR;
    n_nxt.tdo = (t_r.st == bsctap_pkg::SH_IR) ? t_r.ir_sh[0] : t_r.dr_sh[0];
    if (t_rst) begin
      n_nxt.oe = 1'b0;
      n_nxt.tdo = 1'b0;
    end
  end

  always_ff @(negedge tck) begin
    n_r <= n_nxt;
  end

  // pull-ups are pad cells; released tdo floats to the pull level
  assign tdo = n_r.tdo;
  assign tdo_oe = n_r.oe;

  // system side: update events and byte handshake cross by toggles
  assign push_w.valid = c_r.req_st != c_r.ack;
  assign push_w.data = t_r.cfg_byte;

  always_comb begin
    c_nxt = c_r;
    c_nxt.upd_s = {c_r.upd_s[1:0], t_r.upd_tgl};
    c_nxt.upd_st = settle(c_r.upd_st, c_r.upd_s[1], c_r.upd_s[2]);
    c_nxt.ext_s = {c_r.ext_s[1:0], t_r.ext_lvl};
    c_nxt.ext_st = settle(c_r.ext_st, c_r.ext_s[1], c_r.ext_s[2]);
    c_nxt.req_s = {c_r.req_s[1:0], t_r.req_tgl};
    c_nxt.req_st = settle(c_r.req_st, c_r.req_s[1], c_r.req_s[2]);
    // update word is quiet for many tck periods after its toggle
    if (c_r.upd_st != c_r.upd_seen) begin
      c_nxt.upd_copy = t_r.bsr_upd;
      c_nxt.upd_seen = c_r.upd_st;
    end
    // byte stays held until acked; a full fifo stalls the ack
    if (push_w.valid && fifo_in_ready) begin
      c_nxt.ack = c_r.req_st;
    end
    if (c_r.ext_st) begin
      c_nxt.pin_out = c_r.upd_copy[2*NPIN-1:NPIN];
      c_nxt.pin_oe = c_r.upd_copy[3*NPIN-1:2*NPIN];
    end else begin
      c_nxt.pin_out = core_out;
      c_nxt.pin_oe = core_oe;
    end
    if (sys_rst) begin
      // absorb whatever the link side holds, so no stale event fires
      c_nxt.upd_st = c_r.upd_s[2];
      c_nxt.upd_seen = c_r.upd_s[2];
      c_nxt.req_st = c_r.req_s[2];
      c_nxt.ack = c_r.req_s[2];
      c_nxt.ext_st = 1'b0;
      c_nxt.upd_copy = '0;
      c_nxt.pin_out = '0;
      c_nxt.pin_oe = '0;
    end
  end

  always_ff @(posedge clk) begin
    c_r <= c_nxt;
  end

  assign pin_out = c_r.pin_out;
  assign pin_oe = c_r.pin_oe;

  bsctap_fifo #(
    .W(CW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_w.valid),
    .in_ready(fifo_in_ready),
    .in_data(push_w.data),
    .out_valid(cfg_valid),
    .out_ready(cfg_ready),
    .out_data(cfg_data)
  );

endmodule

// [bsctap_checker.sv]
module bsctap_checker #(
  parameter int NPIN = 320
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo_oe,
  input wire logic config_busy,
  input wire logic [NPIN-1:0] core_out,
  input wire logic [NPIN-1:0] core_oe,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [bsctap_pkg::CFG_W-1:0] cfg_data,
  input wire logic cfg_valid,
  input wire logic cfg_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // busy time in clk cycles, saturating; 20 leaves room for both synchronisers
  logic [4:0] busy_cnt_r;
  always_ff @(posedge clk) begin
    if (sys_rst || !config_busy) begin
      busy_cnt_r <= 5'h00;
    end else if (busy_cnt_r != 5'h1f) begin
      busy_cnt_r <= busy_cnt_r + 5'h01;
    end
  end

  property p_shift_exit;
    @(posedge tck) disable iff (sys_rst) tdo_oe && tms |=> !tdo_oe;
  endproperty
  a_shift_exit: assert property (p_shift_exit) else $error("data out driven after leaving shift");
  property p_shift_hold;
    @(posedge tck) disable iff (sys_rst) tdo_oe && !tms |=> tdo_oe;
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("data out released inside shift");
  property p_shift_enter;
    @(posedge tck) disable iff (sys_rst) $rose(tdo_oe) |-> !$past(tms);
  endproperty
  a_shift_enter: assert property (p_shift_enter) else $error("data out driven without entering shift");
  property p_five_ones;
    @(posedge tck) disable iff (sys_rst) tms [*5] |=> !tdo_oe;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("data out driven after five mode ones");
  property p_busy_out;
    @(posedge clk) disable iff (sys_rst) busy_cnt_r >= 5'h14 |-> pin_out == $past(core_out);
  endproperty
  a_busy_out: assert property (p_busy_out) else $error("pin values not from core while busy");
  property p_busy_oe;
    @(posedge clk) disable iff (sys_rst) busy_cnt_r >= 5'h14 |-> pin_oe == $past(core_oe);
  endproperty
  a_busy_oe: assert property (p_busy_oe) else $error("pin enables not from core while busy");
  property p_cfg_valid_hold;
    @(posedge clk) disable iff (sys_rst) cfg_valid && !cfg_ready |=> cfg_valid;
  endproperty
  a_cfg_valid_hold: assert property (p_cfg_valid_hold) else $error("config byte lost while stalled");
  property p_cfg_data_hold;
    @(posedge clk) disable iff (sys_rst) cfg_valid && !cfg_ready |=> $stable(cfg_data);
  endproperty
  a_cfg_data_hold: assert property (p_cfg_data_hold) else $error("config byte changed while stalled");

  c_shift: cover property (@(posedge tck) disable iff (sys_rst) $rose(tdo_oe));
  c_stall: cover property (@(posedge clk) disable iff (sys_rst) cfg_valid && !cfg_ready);
  c_busy: cover property (@(posedge clk) disable iff (sys_rst) busy_cnt_r == 5'h14);
endmodule

bind bsctap_top bsctap_checker #(.NPIN(NPIN)) u_checker (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
  .tdo_oe(tdo_oe), .config_busy(config_busy), .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out),
  .pin_oe(pin_oe), .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready));

// [bsctap_ctrl_model.sv]
module bsctap_ctrl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #15;
    o = tdo_oe ? tdo : 1'b1;
    tck = 1'b1;
    #15;
    tck = 1'b0;
  endtask
  task automatic idle(input logic m, input int n);
    logic o;
    repeat (n) step(m, 1'b1, o);
  endtask
  // standard walk from idle through shift and update
  task automatic scan(input logic ir, input int n, input logic [1023:0] d, output logic [1023:0] q);
    logic o;
    q = '0;
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
    // update hands over the shifted value
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule

// [test_boundary_scan_tap.sv]
module test_boundary_scan_tap;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 320;
  typedef struct {logic [1023:0] v; logic [1023:0] m;} bsctap_exp_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic config_busy = 1'b0;
  logic cfg_ready = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, cfg_valid;
  logic [bsctap_pkg::USER_BITS-1:0] user_sig = '0;
  logic [N-1:0] pin_in = '0, core_out = '0, core_oe = '0, pin_out, pin_oe;
  logic [bsctap_pkg::CFG_W-1:0] cfg_data;
  logic [1023:0] got, pat;
  int num_errors = 0;
  int tests_run = 0;
  bsctap_exp_t exp_q[$];
  logic [7:0] byte_q[$];
  event res_ev;

  initial begin
    forever #10 clk = ~clk;
  end

  bsctap_top #(.NPIN(N), .FIFO_DEPTH(16)) u_dut (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .config_busy(config_busy), .user_sig(user_sig), .pin_in(pin_in),
    .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe), .cfg_data(cfg_data),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready));
  bsctap_ctrl_model u_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  function automatic logic [1023:0] msk(input int n);
    return {1024{1'b1}} >> (1024 - n);
  endfunction
  task automatic fail(input string s);
    num_errors++;
    $display("FAIL %0t %s", $time, s);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic scan(input logic ir, input int n, input logic [1023:0] d, input logic [1023:0] e,
      input logic [1023:0] m);
    exp_q.push_back('{e, m});
    u_ctrl.scan(ir, n, d, got);
    ->res_ev;
  endtask
  task automatic ir(input logic [9:0] op);
    scan(1'b1, 10, op, bsctap_pkg::IR_CAPTURE, msk(10));
  endtask
  task automatic wait_pins(input logic [N-1:0] o, input logic [N-1:0] e);
    int i;
    for (i = 0; i < 40 && !(pin_out === o && pin_oe === e); i++) @(posedge clk);
    tests_run++;
    if (i == 40) begin
      fail("pins");
      conclude();
    end
  endtask
  task automatic drain;
    int i;
    for (i = 0; i < 600 && byte_q.size() != 0; i++) begin
      @(posedge clk);
      cfg_ready <= 1'($urandom);
    end
    @(posedge clk);
    cfg_ready <= 1'b0;
    #1;
    tests_run++;
    if (i == 600 || cfg_valid !== 1'b0) begin
      fail("drain");
      conclude();
    end
  endtask

  always @(res_ev) begin
    tests_run++;
    if (exp_q.size() == 0 || ((got ^ exp_q[0].v) & exp_q[0].m) !== '0) fail("scan data");
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  always @(posedge clk) begin
    if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
      tests_run++;
      if (byte_q.size() == 0 || cfg_data !== byte_q[0]) fail("config byte");
      if (byte_q.size() != 0) void'(byte_q.pop_front());
    end
  end

  initial begin
    logic [1023:0] e;
    logic [7:0] d;
    void'($urandom(32'h0000_a2cd));
    user_sig <= bsctap_pkg::USER_BITS'($urandom);
    fork
      u_ctrl.idle(1'b1, 6);
      repeat (6) @(posedge clk);
    join
    @(posedge clk);
    sys_rst <= 1'b0;
    u_ctrl.idle(1'b1, 5);
    scan(1'b0, 32, '0, {bsctap_pkg::ID_VERSION, bsctap_pkg::ID_PART, bsctap_pkg::ID_MAKER, 1'b1}, msk(32));
    ir(bsctap_pkg::OP_USERCODE);
    scan(1'b0, 32, '0, {bsctap_pkg::SIG_FIXED, user_sig}, msk(32));
    for (int k = 0; k < 2; k++) begin
      ir(k ? 10'h155 : bsctap_pkg::OP_BYPASS);
      pat = {$urandom, $urandom};
      scan(1'b0, 9, pat, {pat[7:0], 1'b0}, msk(9));
    end
    @(posedge clk);
    for (int k = 0; k < N; k++) begin
      pin_in[k] <= 1'($urandom);
      core_out[k] <= 1'($urandom);
      core_oe[k] <= 1'($urandom);
    end
    for (int k = 0; k < 32; k++) pat[k*32+:32] = $urandom;
    @(posedge clk);
    ir(bsctap_pkg::OP_SAMPLE);
    scan(1'b0, 960, pat, {core_oe, core_out, pin_in}, msk(960));
    ir(bsctap_pkg::OP_EXTEST);
    wait_pins(pat[2*N-1:N], pat[3*N-1:2*N]);
    scan(1'b0, 960, '0, {core_oe, core_out, pin_in}, msk(960));
    wait_pins('0, '0);
    @(posedge clk);
    config_busy <= 1'b1;
    ir(bsctap_pkg::OP_SAMPLE);
    scan(1'b0, 2, 2'h1, 2'h2, msk(2));
    ir(bsctap_pkg::OP_EXTEST);
    wait_pins(core_out, core_oe);
    @(posedge clk);
    config_busy <= 1'b0;
    // fill past the fifo, overflow, then drain with stalls
    ir(bsctap_pkg::OP_CFG_LOAD);
    for (int b = 1; b <= 20; b++) begin
      if (b == 20) begin
        drain();
        u_ctrl.idle(1'b0, 10);
      end
      d = 8'($urandom);
      if (b <= 17 || b == 20) byte_q.push_back(d);
      e = b < 18 ? 0 : b == 18 ? 1 : b == 19 ? 3 : 2;
      scan(1'b0, 8, d, e, msk(2));
      u_ctrl.idle(1'b0, 10);
    end
    drain();
    conclude();
  end
endmodule
